// ### logic/pbm_pkg.sv
// Package: constants for the port B low-pin address mux.
// Assumes a 32-bit AXI4-Lite register bus on sys_clk.
package pbm_pkg;
  localparam int NPIN = 4;
  localparam int AW = 4;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [AW-1:0] OFF_PER = 4'h0;
  localparam logic [AW-1:0] OFF_PUR = 4'h4;
  localparam logic [AW-1:0] OFF_BCR = 4'h8;
  localparam logic [AW-1:0] OFF_STAT = 4'hC;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int BCR_DRV_BIT = 0;
  localparam int STAT_SEL_LSB = 0;
  localparam int STAT_OVR_BIT = 4;
  localparam int STAT_BUS_BIT = 5;
  localparam logic [NPIN-1:0] PUR_RST = 4'hF;
  localparam logic [NPIN-1:0] DIR_RST = 4'h0;
  localparam logic DRV_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {BOOT_HOLD, BOOT_LATCH, BOOT_RUN} pbm_boot_t;
endpackage

// ### logic/pbm_pin_cell.sv
// Holds one pin's output mux: GPIO versus upper address line.
// Assumes the main block supplies selection and bus activity.
`timescale 1ns/10ps
module pbm_pin_cell (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic addrSel,
  input wire logic busActive,
  input wire logic driveKeep,
  input wire logic addrBit,
  input wire logic gpioOut,
  input wire logic gpioDir,
  input wire logic pullEn,
  output logic padOut,
  output logic padOe,
  output logic padPull
);
  wire addrOe = busActive | driveKeep; // R02
  wire outNxt = addrSel ? addrBit : gpioOut; // R01
  wire oeNxt = addrSel ? addrOe : gpioDir; // R01
  wire pullNxt = pullEn; // R06
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      padOut <= 1'b0;
      padOe <= 1'b0; // R08
      padPull <= 1'b1; // R08
    end else begin
      padOut <= outNxt;
      padOe <= oeNxt;
      padPull <= pullNxt;
    end
  end
endmodule

// ### logic/pbm_port_b_mux.sv
// Top of the port B low-pin function mux with AXI4-Lite registers.
// Assumes synchronous boot straps, bus activity and GPIO data inputs.
//
// Behaviour
// R01 - Each pin is GPIO or upper address
// R02 - Idle bus: tri-state or drive per bit
// R03 - Software should set bus drive bit
// R04 - Reset function from boot, mode, security
// R05 - Enable register write always overrides selection (here only when s_axi_wstrb[0] is set; other writes leave it)
// R06 - Cleared pull-up bit disables pull-up
// R07 - Pull-up bit index equals pin index
// R08 - In reset: inputs, pull-ups on
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module pbm_port_b_mux (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic externalBootSelect,
  input wire logic externalBusModeSelect,
  input wire logic flashSecure,
  input wire logic busActive,
  input wire logic [pbm_pkg::NPIN-1:0] upperAddress,
  input wire logic [pbm_pkg::NPIN-1:0] gpioOut,
  input wire logic [pbm_pkg::NPIN-1:0] gpioDir,
  input wire logic [pbm_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pbm_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [pbm_pkg::NPIN-1:0] padOut,
  output logic [pbm_pkg::NPIN-1:0] padOe,
  output logic [pbm_pkg::NPIN-1:0] padPull,
  output logic externalMemCtrlOe
);
  import pbm_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  pbm_boot_t bootState_r;
  logic [NPIN-1:0] portBPeripheralEnable_r;
  logic [NPIN-1:0] portBPullupEnable_r;
  logic busDriveKeep_r;
  logic override_r;
  logic [AW-1:0] awAddr_r;
  logic awHeld_r;
  logic [31:0] wData_r;
  logic wHeld_r;
  logic wLane0_r;
  // ----------------------------------------
  // Startup selection
  // ----------------------------------------
  // Address use only when booting external in bus mode and not secured
  wire bootAddrUse = externalBootSelect & externalBusModeSelect & ~flashSecure; // R04
  wire [NPIN-1:0] bootSel = {NPIN{bootAddrUse}};
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bootState_r <= BOOT_HOLD;
    end else begin
      case (bootState_r)
        BOOT_HOLD: bootState_r <= BOOT_LATCH;
        BOOT_LATCH: bootState_r <= BOOT_RUN;
        BOOT_RUN: bootState_r <= BOOT_RUN;
        default: bootState_r <= BOOT_HOLD;
      endcase
    end
  end
  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire [AW-1:0] wAddr = awTake ? s_axi_awaddr : awHeld_r ? awAddr_r : '0;
  wire [31:0] wDat = wTake ? s_axi_wdata : wData_r;
  wire wLane0 = wTake ? s_axi_wstrb[0] : wLane0_r;
  wire haveAw = awTake | awHeld_r;
  wire haveW = wTake | wHeld_r;
  wire doWrite = haveAw & haveW & ~s_axi_bvalid;
  wire wrPer = doWrite & wLane0 & (wAddr == OFF_PER);
  wire wrPur = doWrite & wLane0 & (wAddr == OFF_PUR);
  wire wrBcr = doWrite & wLane0 & (wAddr == OFF_BCR);
  wire wrOk = (wAddr == OFF_PER) | (wAddr == OFF_PUR) | (wAddr == OFF_BCR);
  wire latchBoot = (bootState_r == BOOT_LATCH) & ~override_r;
  wire [NPIN-1:0] perNxt = wrPer ? wDat[NPIN-1:0] : // R05
    latchBoot ? bootSel : portBPeripheralEnable_r; // R04
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      portBPeripheralEnable_r <= '0;
      override_r <= 1'b0;
    end else begin
      portBPeripheralEnable_r <= perNxt;
      if (wrPer) override_r <= 1'b1; // R05
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      portBPullupEnable_r <= PUR_RST; // R08
    end else if (wrPur) begin
      portBPullupEnable_r <= wDat[NPIN-1:0]; // R07
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busDriveKeep_r <= DRV_RST;
    end else if (wrBcr) begin
      busDriveKeep_r <= wDat[BCR_DRV_BIT]; // R02
    end
  end
  // ----------------------------------------
  // Write address channel
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else begin
      s_axi_awready <= ~haveAw & ~s_axi_bvalid & ~doWrite;
      awHeld_r <= haveAw & ~doWrite;
      if (awTake) awAddr_r <= s_axi_awaddr;
    end
  end
  // ----------------------------------------
  // Write data channel
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_wready <= 1'b0;
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wLane0_r <= 1'b0;
    end else begin
      s_axi_wready <= ~haveW & ~s_axi_bvalid & ~doWrite;
      wHeld_r <= haveW & ~doWrite;
      if (wTake) begin
        wData_r <= s_axi_wdata;
        wLane0_r <= s_axi_wstrb[0];
      end
    end
  end
  // ----------------------------------------
  // Write response channel
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire [31:0] statWord = {26'h0, busActive, override_r, portBPeripheralEnable_r};
  wire rdOk = (s_axi_araddr == OFF_PER) | (s_axi_araddr == OFF_PUR) |
    (s_axi_araddr == OFF_BCR) | (s_axi_araddr == OFF_STAT);
  wire [31:0] rdMux =
    (s_axi_araddr == OFF_PER) ? {28'h0, portBPeripheralEnable_r} :
    (s_axi_araddr == OFF_PUR) ? {28'h0, portBPullupEnable_r} :
    (s_axi_araddr == OFF_BCR) ? {31'h0, busDriveKeep_r} :
    (s_axi_araddr == OFF_STAT) ? statWord : 32'h0;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~arTake;
    end
  end
  // ----------------------------------------
  // Read data channel
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Pins
  // ----------------------------------------
  for (genvar i = 0; i < NPIN; i++) begin : gPin
    pbm_pin_cell uCell (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .addrSel(portBPeripheralEnable_r[i]), // R01
      .busActive(busActive),
      .driveKeep(busDriveKeep_r),
      .addrBit(upperAddress[i]),
      .gpioOut(gpioOut[i]),
      .gpioDir(gpioDir[i]),
      .pullEn(portBPullupEnable_r[i]), // R07
      .padOut(padOut[i]),
      .padOe(padOe[i]),
      .padPull(padPull[i])
    );
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) externalMemCtrlOe <= 1'b0;
    else externalMemCtrlOe <= busActive | busDriveKeep_r; // R02
  end
endmodule

// ### dv/pbm_port_b_mux_properties.sv
// Checker for the port B low-pin mux top ports.
// Assumes a bind onto pbm_port_b_mux; one clock domain.
`timescale 1ns/10ps
module pbm_port_b_mux_properties (
  input wire logic sys_clk, rstn, busActive, externalMemCtrlOe,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [3:0] s_axi_araddr, gpioDir, padOe, padPull,
  input wire logic [31:0] s_axi_rdata
);
  import pbm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  rst_state_a: assert property ($rose(rstn) |-> padOe == DIR_RST && padPull == PUR_RST)
    else $error("pins not in reset state");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while busy");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while busy");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
  ctrl_oe_a: assert property (busActive |=> externalMemCtrlOe)
    else $error("control not driven");
  bus_oe_a: assert property (busActive && gpioDir == 4'hF |=> padOe == 4'hF)
    else $error("pins not driven");
endmodule

// ### dv/pbm_mem_model.sv
// External memory seen through the upper address lines.
// Assumes pads with pull-ups; undriven lines without pull drift.
`timescale 1ns/10ps
module pbm_mem_model (
  input wire logic sys_clk,
  input wire logic [3:0] padOut, padOe, padPull,
  output logic [3:0] seenAddr
);
  initial seenAddr = 4'h0;
  // Wire level: driven, pulled up, or drifting
  always @(posedge sys_clk) begin
    seenAddr <= (padOut & padOe) | (~padOe & (padPull | ~seenAddr));
  end
endmodule

// ### dv/pbm_port_b_mux_test.sv
// Bench for the port B low-pin mux with a behavioural model.
// Assumes the design, its package and the memory model.
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module port_b_address_pin_mux_test;
  import pbm_pkg::*;
  logic sys_clk = 0, rstn = 0, externalBootSelect = 0, externalBusModeSelect = 0;
  logic flashSecure = 0, busActive = 0, keep = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, externalMemCtrlOe;
  logic [3:0] upperAddress = 0, gpioOut = 0, gpioDir = 0, s_axi_awaddr = 0;
  logic [3:0] s_axi_araddr = 0, s_axi_wstrb = 4'hF, padOut, padOe, padPull, seenAddr;
  logic [3:0] sel, pur, eo, ex;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int seed = 43, err_total = 0, tests_run = 0;
  pbm_port_b_mux pbm_port_b_mux_i (.*);
  pbm_mem_model pbm_mem_model_i (.sys_clk, .padOut, .padOe, .padPull, .seenAddr);
  always #2 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Bus tasks and pin check
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo(input bit ok);
    if (!ok) begin
      err_total++;
      $display("[ERR] handshake exp 1 got 0");
      end_of_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    int n;
    bit aw, w, b;
    n = 0; aw = 0; w = 0; b = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b && n < 99) begin
      @(negedge sys_clk);
      aw |= s_axi_awready; w |= s_axi_wready; b = s_axi_bvalid;
      if (b) `CHK("bresp", er, s_axi_bresp)
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      n++;
    end
    s_axi_bready <= 0;
    tmo(b);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    bit ar, b;
    n = 0; ar = 0; b = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (!b && n < 99) begin
      @(negedge sys_clk);
      ar |= s_axi_arready; b = s_axi_rvalid; v = s_axi_rdata; r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 0;
      n++;
    end
    s_axi_rready <= 0;
    tmo(b);
  endtask
  task automatic pins();
    @(posedge sys_clk);
    busActive <= 1'($random(seed));
    upperAddress <= 4'($random(seed));
    gpioOut <= 4'($random(seed));
    gpioDir <= 4'($random(seed));
    @(posedge sys_clk);
    @(negedge sys_clk);
    eo = (sel & {4{busActive | keep}}) | (~sel & gpioDir);
    ex = (sel & upperAddress) | (~sel & gpioOut);
    `CHK("padOe", eo, padOe)
    `CHK("padOut", ex, padOut)
    `CHK("padPull", pur, padPull)
    `CHK("ctrlOe", busActive | keep, externalMemCtrlOe)
    @(negedge sys_clk);
    `CHK("seenAddr", ((ex & eo) | ~eo) & (eo | pur), seenAddr & (eo | pur))
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      {externalBootSelect, externalBusModeSelect, flashSecure} <= k[2:0];
      rstn <= 0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1;
      repeat (3) @(posedge sys_clk);
      sel = (k == 6) ? 4'hF : 4'h0;
      pur = PUR_RST;
      keep = DRV_RST;
      rd(OFF_STAT, d, rs);
      `CHK("stat", {1'b0, sel}, d[4:0])
      pins();
    end
    wr(OFF_BCR, 32'h1);
    keep = 1;
    repeat (6) begin
      sel = 4'($random(seed));
      wr(OFF_PER, {28'h0, sel});
      pins();
      pur = 4'($random(seed));
      wr(OFF_PUR, {28'h0, pur});
      pins();
    end
    rd(OFF_STAT, d, rs);
    `CHK("statOvr", {busActive, 1'b1, sel}, d[5:0])
    rd(OFF_PUR, d, rs);
    `CHK("pur", {28'h0, pur}, d)
    rd(4'h2, d, rs);
    `CHK("rresp", RESP_SLVERR, rs)
    `CHK("rdata", 32'h0, d)
    wr(4'h2, 32'hF, RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    wr(OFF_PER, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(OFF_PER, d, rs);
    `CHK("perKept", {28'h0, sel}, d)
    wr(OFF_BCR, 32'h0);
    keep = 0;
    repeat (3) pins();
    end_of_test();
  end
endmodule
bind pbm_port_b_mux pbm_port_b_mux_properties chk_i (.*);
